// ---- verilog/csub_buffer.sv ----
// Double-buffered channel status and user data store with APB access
`timescale 1ns/100ps
`default_nettype none
module csub_buffer #(
  parameter int BLOCK_FRAMES = csub_pkg::BLOCK_FRAMES,
  parameter int BUF_WORDS = csub_pkg::BUF_WORDS,
  parameter int RSV_WORDS = csub_pkg::RSV_WORDS,
  parameter int COPY_GAP_FRAMES = csub_pkg::COPY_GAP_FRAMES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csub_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_frame,
  input wire logic rx_block_start,
  input wire logic rx_cs_a,
  input wire logic rx_cs_b,
  input wire logic rx_u_a,
  input wire logic rx_u_b,
  output logic irq
);
  import csub_pkg::*;

  // Both buffer windows must fit the byte map without overlap
  if (BLOCK_FRAMES != BUF_WORDS * 8 || RSV_WORDS > BUF_WORDS || BUF_WORDS > 32
      || COPY_GAP_FRAMES > 255 || COPY_GAP_FRAMES < 1
      || BUF_WORDS * 4 > int'(U_BASE - CS_BASE)
      || int'(U_BASE) + BUF_WORDS * 4 > 256) begin : g_chk
    $error("csub_buffer: unsupported sizes");
  end

  // ***************************************************
  // Declarations
  // ***************************************************
  logic [CTRL_W-1:0] ctrl;
  logic [STAT_W-1:0] status;
  logic [STAT_W-1:0] next_status;
  logic [STAT_W-1:0] mask;
  logic [7:0] fcnt;
  logic [7:0] cur_pos;
  logic blk_sync;
  logic block_done;
  logic [7:0] gap_cnt;
  logic copy_req;
  logic copy_start;
  logic copy_busy;
  logic [4:0] copy_idx;
  logic copy_last;
  logic ev_done;
  logic ev_drop;
  logic [7:0] d_cs_a [BUF_WORDS];
  logic [7:0] d_cs_b [BUF_WORDS];
  logic [7:0] d_u_a [BUF_WORDS];
  logic [7:0] d_u_b [BUF_WORDS];
  logic acc;
  logic commit;
  logic is_ctrl;
  logic is_stat;
  logic is_mask;
  logic is_cs;
  logic is_u;
  logic [4:0] buf_idx;
  logic ram_ok;
  logic cs_wr_ok;
  logic [3:0] ram_we;
  logic [4:0] ram_waddr;
  logic [31:0] ram_wdata;
  logic [31:0] ram_rdata;
  logic [15:0] u_word;
  logic [31:0] reg_rdata;

  // ***************************************************
  // Frame position within the block
  // ***************************************************
  assign cur_pos = rx_block_start ? 8'h00 : fcnt;
  assign block_done = rx_frame && blk_sync && (cur_pos == 8'(BLOCK_FRAMES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcnt <= 8'h00;
      blk_sync <= 1'b0;
    end else if (rx_frame) begin
      if (cur_pos == 8'(BLOCK_FRAMES - 1)) begin
        fcnt <= 8'h00;
      end else begin
        fcnt <= cur_pos + 8'h01;
      end
      if (rx_block_start) begin
        blk_sync <= 1'b1;
      end
    end
  end

  // ***************************************************
  // Staging buffer, earliest bit in the MSB
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < BUF_WORDS; i++) begin
        d_cs_a[i] <= 8'h00;
        d_cs_b[i] <= 8'h00;
        d_u_a[i] <= 8'h00;
        d_u_b[i] <= 8'h00;
      end
    end else if (rx_frame) begin
      d_cs_a[cur_pos[7:3]][3'd7 - cur_pos[2:0]] <= rx_cs_a;
      d_cs_b[cur_pos[7:3]][3'd7 - cur_pos[2:0]] <= rx_cs_b;
      d_u_a[cur_pos[7:3]][3'd7 - cur_pos[2:0]] <= rx_u_a;
      d_u_b[cur_pos[7:3]][3'd7 - cur_pos[2:0]] <= rx_u_b;
    end
  end

  // ***************************************************
  // Copy scheduling
  // ***************************************************
  // Never start under a write's access phase, which would drop its data
  assign copy_start = copy_req && !copy_busy && !(psel && penable && pwrite);
  assign copy_last = copy_busy && (copy_idx == 5'(BUF_WORDS - 1));
  assign ev_done = copy_last;
  assign ev_drop = block_done && (ctrl[CTRL_INHIBIT] || gap_cnt != 8'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      copy_req <= 1'b0;
    end else if (block_done && !ctrl[CTRL_INHIBIT] && gap_cnt == 8'h00) begin
      copy_req <= 1'b1;
    end else if (copy_start) begin
      copy_req <= 1'b0;
    end
  end

  // Frames left before another copy may run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt <= 8'h00;
    end else if (copy_start) begin
      gap_cnt <= 8'(COPY_GAP_FRAMES);
    end else if (rx_frame && gap_cnt != 8'h00) begin
      gap_cnt <= gap_cnt - 8'h01;
    end
  end

  // Whole block walked one word per cycle, buffer reads stalled meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      copy_busy <= 1'b0;
      copy_idx <= 5'h00;
    end else if (copy_start) begin
      copy_busy <= 1'b1;
      copy_idx <= 5'h00;
    end else if (copy_last) begin
      copy_busy <= 1'b0;
      copy_idx <= 5'h00;
    end else if (copy_busy) begin
      copy_idx <= copy_idx + 5'h01;
    end
  end

  // ***************************************************
  // Readable buffer write port
  // ***************************************************
  always_comb begin
    ram_we = 4'h0;
    ram_waddr = buf_idx;
    ram_wdata = 32'h0000_0000;
    if (copy_busy) begin
      ram_waddr = copy_idx;
      ram_wdata = {d_cs_a[copy_idx], d_cs_b[copy_idx], d_u_a[copy_idx], d_u_b[copy_idx]};
      // Reserved words keep their status lanes, user lanes always copy
      ram_we = 4'h3;
      if (!(ctrl[CTRL_RESERVE] && int'(copy_idx) < RSV_WORDS)) begin
        ram_we = 4'hf;
      end
    end else if (commit && is_cs) begin
      if (ctrl[CTRL_TWO_BYTE]) begin
        ram_wdata = {pwdata[15:8], pwdata[7:0], 16'h0000};
        ram_we = 4'hc;
      end else begin
        ram_wdata = {pwdata[7:0], pwdata[7:0], 16'h0000};
        ram_we = ctrl[CTRL_CHAN_B] ? 4'h4 : 4'h8;
      end
    end
  end

  csub_ram #(
    .WORDS(BUF_WORDS),
    .AW(5),
    .LANES(4)
  ) u_ebuf (
    .pclk(pclk),
    .presetn(presetn),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(buf_idx),
    .rdata(ram_rdata)
  );

  // ***************************************************
  // APB decode
  // ***************************************************
  assign acc = psel && penable && !pready;
  assign commit = psel && penable && pready && pwrite && !pslverr;
  assign is_ctrl = (paddr == CTRL_OFS);
  assign is_stat = (paddr == STAT_OFS);
  assign is_mask = (paddr == MASK_OFS);
  assign is_cs = (paddr[1:0] == 2'b00) && (paddr >= CS_BASE)
                 && (paddr < CS_BASE + 8'(BUF_WORDS * 4));
  assign is_u = (paddr[1:0] == 2'b00) && (paddr >= U_BASE)
                && (paddr < U_BASE + 8'(BUF_WORDS * 4));
  assign buf_idx = is_u ? 5'((paddr - U_BASE) >> 2) : 5'((paddr - CS_BASE) >> 2);
  assign cs_wr_ok = ctrl[CTRL_RESERVE] && (int'(buf_idx) < RSV_WORDS);

  // User bits interleaved A over B
  for (genvar b = 0; b < 8; b++) begin : g_ilv
    assign u_word[2*b+1] = ram_rdata[8+b];
    assign u_word[2*b] = ram_rdata[b];
  end

  always_comb begin
    reg_rdata = 32'h0000_0000;
    if (is_ctrl) begin
      reg_rdata[CTRL_W-1:0] = ctrl;
    end else if (is_stat) begin
      reg_rdata[STAT_W-1:0] = status;
      reg_rdata[STAT_SYNC] = blk_sync;
      reg_rdata[STAT_BUSY] = copy_busy;
    end else if (is_mask) begin
      reg_rdata[STAT_W-1:0] = mask;
    end
  end

  // Buffer data valid once the read port saw a quiet cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_ok <= 1'b0;
    end else begin
      ram_ok <= psel && !copy_busy;
    end
  end

  // ***************************************************
  // APB answer
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (acc) begin
      // Status buffer accesses and user buffer reads wait out a running copy
      if (is_ctrl || is_stat || is_mask) begin
        pready <= 1'b1;
        pslverr <= 1'b0;
        prdata <= pwrite ? 32'h0000_0000 : reg_rdata;
      end else if (is_cs && pwrite) begin
        if (!copy_busy) begin
          pready <= 1'b1;
          pslverr <= !cs_wr_ok;
          prdata <= 32'h0000_0000;
        end
      end else if (is_cs) begin
        if (ram_ok && !copy_busy) begin
          pready <= 1'b1;
          pslverr <= 1'b0;
          if (ctrl[CTRL_TWO_BYTE]) begin
            prdata <= {16'h0000, ram_rdata[31:24], ram_rdata[23:16]};
          end else if (ctrl[CTRL_CHAN_B]) begin
            prdata <= {24'h00_0000, ram_rdata[23:16]};
          end else begin
            prdata <= {24'h00_0000, ram_rdata[31:24]};
          end
        end
      end else if (is_u && !pwrite) begin
        if (ram_ok && !copy_busy) begin
          pready <= 1'b1;
          pslverr <= 1'b0;
          prdata <= {16'h0000, u_word};
        end
      end else begin
        pready <= 1'b1;
        pslverr <= 1'b1;
        prdata <= 32'h0000_0000;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ***************************************************
  // Control and mask registers
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
    end else if (commit && is_ctrl) begin
      ctrl <= pwdata[CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= MASK_RST;
    end else if (commit && is_mask) begin
      mask <= pwdata[STAT_W-1:0];
    end
  end

  // ***************************************************
  // Sticky events and interrupt
  // ***************************************************
  // An event in the clearing cycle keeps its bit set
  always_comb begin
    next_status = status;
    if (commit && is_stat) begin
      next_status = status & ~pwdata[STAT_W-1:0];
    end
    next_status = next_status | {ev_drop, ev_done};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

endmodule
`default_nettype wire

// ---- verilog/csub_pkg.sv ----
// Constants shared by the channel status and user data block buffer
// Overview of operation
// - Hold 384 status and 384 user bits
// - Staging buffer feeds readable buffer by copies
// - Earliest received bit sits in byte MSB
// - Status byte 0 at address 32
// - Interrupt on every copy when enabled
// - Inhibit bit suppresses copies
// - At least 24 frames between copies
// - Reserve keeps first five bytes untouched
// - Readable buffer is 24 words, A high
// - Control bit picks one or two byte
// - One byte mode returns chosen channel
// - Two byte mode returns A then B
// - User buffer cascaded, always two byte
// - User word interleaves A and B bits
// - User bytes returned in arrival order
// - Reset clears all state and registers
package csub_pkg;

  // ***************************************************
  // Sizes
  // ***************************************************
  localparam int BLOCK_FRAMES = 192;
  localparam int BUF_WORDS = 24;
  localparam int RSV_WORDS = 5;
  localparam int COPY_GAP_FRAMES = 24;
  localparam int ADDR_W = 8;

  // ***************************************************
  // Register byte addresses
  // ***************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] CS_BASE = 8'h20;
  localparam logic [7:0] U_BASE = 8'h80;

  // ***************************************************
  // Control fields and reset value
  // ***************************************************
  localparam int CTRL_INHIBIT = 0;
  localparam int CTRL_RESERVE = 1;
  localparam int CTRL_TWO_BYTE = 2;
  localparam int CTRL_CHAN_B = 3;
  localparam int CTRL_W = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // ***************************************************
  // Status fields
  // ***************************************************
  localparam int STAT_COPY_DONE = 0;
  localparam int STAT_COPY_DROP = 1;
  localparam int STAT_W = 2;
  localparam int STAT_SYNC = 8;
  localparam int STAT_BUSY = 9;
  localparam logic [1:0] MASK_RST = 2'h0;

endpackage

// ---- verilog/csub_ram.sv ----
// Byte-lane memory holding the readable status and user words
`timescale 1ns/100ps
`default_nettype none
module csub_ram #(
  parameter int WORDS = 24,
  parameter int AW = 5,
  parameter int LANES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [LANES-1:0] we,
  input wire logic [AW-1:0] waddr,
  input wire logic [LANES*8-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [LANES*8-1:0] rdata
);

  logic [LANES*8-1:0] mem [WORDS];

  if (WORDS > (1 << AW)) begin : g_chk
    $error("csub_ram: address too narrow");
  end

  // ***************************************************
  // Write port, one lane per byte
  // ***************************************************
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        for (int w = 0; w < WORDS; w++) begin
          mem[w][l*8 +: 8] <= 8'h00;
        end
      end else if (we[l] && (int'(waddr) < WORDS)) begin
        mem[waddr][l*8 +: 8] <= wdata[l*8 +: 8];
      end
    end
  end

  // ***************************************************
  // Registered read port
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else if (int'(raddr) < WORDS) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= '0;
    end
  end

endmodule
`default_nettype wire

// ---- verif/csub_buffer_asserts.sv ----
// Port checker for the block buffer
`timescale 1ns/100ps
`default_nettype none
module csub_buffer_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [csub_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  import csub_pkg::*;
  logic wr_done;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_done <= 1'b0;
    else wr_done <= pready && pwrite;
  end
  // ****
  // Port relations
  // ****
  AST_RST_QUIET: assert property ($rose(presetn) |-> !pready && !pslverr && !irq)
    else $error("Outputs busy after reset");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("Ready longer than one cycle");
  AST_READY_SEL: assert property (pready |-> psel && penable)
    else $error("Ready outside a transfer");
  AST_REG_FAST: assert property ((psel && !penable && paddr <= MASK_OFS) ##1 (psel && penable)
    |=> pready) else $error("Register answer late");
  AST_RDATA_HOLD: assert property ($changed(prdata) |-> pready)
    else $error("Read data moved without answer");
  AST_U_RO: assert property (pready && pwrite && paddr >= U_BASE |-> pslverr)
    else $error("User buffer write accepted");
  AST_U_FORM: assert property (pready && !pwrite && paddr >= U_BASE && !pslverr
    |-> prdata[31:16] == 16'h0000) else $error("User word upper half set");
  AST_CS_FORM: assert property (pready && !pwrite && paddr >= CS_BASE && paddr < U_BASE
    && !pslverr |-> prdata[31:16] == 16'h0000) else $error("Status word upper half set");
  AST_CS_RSV: assert property (pready && pwrite && paddr >= CS_BASE + 8'(4 * RSV_WORDS)
    && paddr < U_BASE |-> pslverr) else $error("Unreserved status write accepted");
  AST_IRQ_FALL: assert property ($fell(irq) |-> wr_done || $past(wr_done))
    else $error("Interrupt dropped without a write");
endmodule
bind csub_buffer csub_buffer_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));
`default_nettype wire

// ---- verif/csub_rx_src.sv ----
// Receiver stream model feeding status and user bits
`timescale 1ns/100ps
`default_nettype none
module csub_rx_src #(
  parameter int GAP = 30
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] seed,
  output logic rx_frame,
  output logic rx_block_start,
  output logic rx_cs_a,
  output logic rx_cs_b,
  output logic rx_u_a,
  output logic rx_u_b,
  output logic [7:0] blocks
);
  logic [7:0] cnt;
  logic [7:0] frm;
  logic [7:0] n;
  logic [7:0] ba;
  logic [7:0] ua;
  logic [7:0] ub;
  logic [2:0] k;
  assign n = {3'h0, frm[7:3]};
  assign k = 3'd7 - frm[2:0];
  assign ba = seed ^ n;
  assign ua = seed + n;
  assign ub = 8'h5a ^ n;
  assign rx_frame = (cnt == 8'(GAP - 1));
  assign rx_block_start = rx_frame && frm == 8'h00;
  // Lines show inverted bits between frames
  assign rx_cs_a = ba[k] ^ !rx_frame;
  assign rx_cs_b = !ba[k] ^ !rx_frame;
  assign rx_u_a = ua[k] ^ !rx_frame;
  assign rx_u_b = ub[k] ^ !rx_frame;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 8'h00;
      frm <= 8'h00;
      blocks <= 8'h00;
    end else begin
      cnt <= rx_frame ? 8'h00 : cnt + 8'h01;
      if (rx_frame) begin
        frm <= (frm == 8'd191) ? 8'h00 : frm + 8'h01;
        if (frm == 8'd191) begin
          blocks <= blocks + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the block buffer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import csub_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_frame, rx_block_start, rx_cs_a, rx_cs_b, rx_u_a, rx_u_b, irq;
  logic [7:0] seed;
  logic [7:0] s0;
  logic [7:0] blocks;
  int n_fail;
  int comparisons;

  csub_buffer i_csub_buffer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_frame(rx_frame), .rx_block_start(rx_block_start),
    .rx_cs_a(rx_cs_a), .rx_cs_b(rx_cs_b), .rx_u_a(rx_u_a), .rx_u_b(rx_u_b), .irq(irq));
  csub_rx_src i_csub_rx_src (.pclk(pclk), .presetn(presetn), .seed(seed),
    .rx_frame(rx_frame), .rx_block_start(rx_block_start), .rx_cs_a(rx_cs_a),
    .rx_cs_b(rx_cs_b), .rx_u_a(rx_u_a), .rx_u_b(rx_u_b), .blocks(blocks));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic xe, output logic [31:0] r);
    int t;
    t = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 200);
    chk("pready", 32'h1, {31'h0, pready});
    r = prdata;
    chk("pslverr", {31'h0, xe}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic xe);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, xe, r);
    if (!xe) chk("prdata", exp, r);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    logic [31:0] r;
    apb(1'b1, a, d, xe, r);
  endtask

  function automatic logic [31:0] csw(input logic [7:0] s, input int i);
    return {16'h0, s ^ 8'(i), ~(s ^ 8'(i))};
  endfunction

  function automatic logic [31:0] uw(input logic [7:0] s, input int i);
    logic [7:0] a;
    logic [7:0] b;
    logic [31:0] w;
    a = s + 8'(i);
    b = 8'h5a ^ 8'(i);
    w = 32'h0;
    for (int j = 0; j < 8; j++) begin
      w[2*j+1] = a[j];
      w[2*j] = b[j];
    end
    return w;
  endfunction

  task automatic wait_irq;
    int t;
    t = 0;
    while (irq !== 1'b1 && t < 20000) begin
      @(posedge pclk);
      t++;
    end
    chk("irq", 32'h1, {31'h0, irq});
  endtask

  task automatic wait_blk;
    logic [7:0] b;
    int t;
    b = blocks;
    t = 0;
    while (blocks === b && t < 8000) begin
      @(posedge pclk);
      t++;
    end
    chk("block advance", 32'h1, {31'h0, blocks !== b});
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 8'h3c;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTRL_OFS, 32'h0, 1'b0);
    rd(STAT_OFS, 32'h0, 1'b0);
    rd(MASK_OFS, 32'h0, 1'b0);
    rd(8'h0c, 32'h0, 1'b1);
    wr(U_BASE, 32'h1, 1'b1);
    wr(CS_BASE, 32'h1, 1'b1);
    wr(MASK_OFS, 32'h1, 1'b0);
    $display("Test reset done");
    wait_irq();
    rd(STAT_OFS, 32'h101, 1'b0);
    wr(STAT_OFS, 32'h1, 1'b0);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(CTRL_OFS, 32'h4, 1'b0);
    for (int i = 0; i < 24; i++) rd(CS_BASE + 8'(4*i), csw(seed, i), 1'b0);
    for (int m = 0; m < 2; m++) begin
      wr(CTRL_OFS, 32'(8*m), 1'b0);
      for (int i = 0; i < 24; i += 23) begin
        rd(CS_BASE + 8'(4*i), {24'h0, 8'(csw(seed, i) >> (8 - 8*m))}, 1'b0);
      end
    end
    for (int i = 0; i < 24; i++) rd(U_BASE + 8'(4*i), uw(seed, i), 1'b0);
    $display("Test copy done");
    wr(CTRL_OFS, 32'h5, 1'b0);
    s0 = seed;
    seed <= 8'ha5;
    wait_blk();
    wait_blk();
    repeat (30) @(posedge pclk);
    rd(STAT_OFS, 32'h102, 1'b0);
    rd(CS_BASE + 8'h04, csw(s0, 1), 1'b0);
    $display("Test inhibit done");
    wr(CTRL_OFS, 32'h6, 1'b0);
    wr(CS_BASE, 32'h0000beef, 1'b0);
    wr(CS_BASE + 8'h14, 32'h1, 1'b1);
    wr(STAT_OFS, 32'h3, 1'b0);
    wait_irq();
    rd(CS_BASE, 32'h0000beef, 1'b0);
    rd(CS_BASE + 8'h04, csw(s0, 1), 1'b0);
    rd(CS_BASE + 8'h14, csw(8'ha5, 5), 1'b0);
    rd(U_BASE + 8'h04, uw(8'ha5, 1), 1'b0);
    $display("Test reserve done");
    report_and_stop();
  end
endmodule
`default_nettype wire
